/* eep_pkg.sv */
// eep_pkg: constants and state types for the two-wire serial memory slave
// assumes a 100 MHz core clock and a bus master that drives the serial clock
package eep_pkg;

  // fixed type code in the upper nibble of the slave address
  localparam logic [3:0] TYPE_CODE = 4'hA;
  // select bits used by the build option without select pins
  localparam logic [2:0] SEL_FIXED_A = 3'h0;
  localparam logic [2:0] SEL_FIXED_B = 3'h4;

  localparam int MEM_DEPTH = 8192;
  localparam int PAGE_BYTES = 32;
  localparam logic [7:0] ERASED = 8'hFF;

  // bit counter: 0..7 data bits, 8 is the acknowledge clock
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [3:0] FIRST_AFTER_START = 4'h1;
  localparam logic [3:0] BIT_TOP = 4'h6;

  // internal programming time
  localparam int CORE_CLK_MHZ = 100;
  localparam int PROG_TIME_MS = 5;
  localparam int PROG_CYCLES_DEF = PROG_TIME_MS * 1000 * CORE_CLK_MHZ;
  localparam int PROG_CNT_W = 19;

  typedef enum logic [2:0] {
    L_IDLE, L_DEV, L_AHI, L_ALO, L_WDAT, L_RDAT
  } eep_lstate_t;

  typedef enum logic {C_IDLE, C_PROG} eep_cstate_t;

  // state clocked on the rising serial clock
  typedef struct packed {
    eep_lstate_t st;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic [12:0] cur;
    logic [4:0] ahi;
    logic [7:0] page;
    logic [4:0] off;
    logic [31:0] mask;
    logic [31:0][7:0] pbuf;
    logic wr_pend;
    logic first_rd;
    logic drv_low;
    logic start_seen;
    logic stop_seen;
    logic busy_s1;
    logic busy_s2;
    logic [2:0] sel_s1;
    logic [2:0] sel_s2;
  } eep_link_t;

  // state clocked on the falling serial clock
  typedef struct packed {
    logic sda_o;
    logic oe_n;
    logic wp_s1;
    logic wp_s2;
    logic wp_lat;
  } eep_drv_t;

  // state clocked on the core clock
  typedef struct packed {
    eep_cstate_t st;
    logic [PROG_CNT_W-1:0] cnt;
    logic stop_s1;
    logic stop_s2;
    logic stop_s3;
    logic pend_s1;
    logic pend_s2;
    logic busy;
  } eep_core_t;

endpackage : eep_pkg

/* eep_slave.sv */
// eep_slave: two-wire serial memory slave, 8192 bytes, 32-byte page writes
// assumes the master drives LINK_SCL and that SDA is wired-and outside
`timescale 1ns/100ps
`default_nettype none
module eep_slave
  import eep_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF,
  parameter bit HAS_SELECT_PINS = 1'b1,
  parameter logic [2:0] FIXED_SELECT = SEL_FIXED_A
) (
  // core clock, enable, reset
  input wire logic CORE_CLK,
  input wire logic CE,
  input wire logic RST,
  // serial bus
  input wire logic LINK_SCL,
  input wire logic SDA_IN,
  output var logic SDA_OUT,
  output var logic SDA_OE_N,
  // straps
  input wire logic DEVICE_SELECT_BIT0,
  input wire logic DEVICE_SELECT_BIT1,
  input wire logic DEVICE_SELECT_BIT2,
  input wire logic WRITE_PROTECT
);

  localparam logic [PROG_CNT_W-1:0] PROG_LAST = PROG_CNT_W'(PROG_CYCLES - 1);

  eep_link_t l;
  eep_link_t ln;
  eep_drv_t d;
  eep_drv_t dn;
  eep_core_t c;
  eep_core_t cn;

  // erased at power-up, not touched by reset
  logic [7:0] mem [0:MEM_DEPTH-1] = '{default: ERASED};
  logic start_tgl;
  logic stop_tgl;
  logic start_pend;
  logic stop_pend;
  logic [7:0] rx_byte;
  logic [2:0] sel;
  logic stop_edge;
  logic commit;

  // start and stop are the only SDA changes while the clock is high
  always_ff @(negedge SDA_IN or posedge RST) begin
    if (RST) begin
      start_tgl <= 1'b0;
    end else if (LINK_SCL) begin
      start_tgl <= ~start_tgl;
    end
  end

  always_ff @(posedge SDA_IN or posedge RST) begin
    if (RST) begin
      stop_tgl <= 1'b0;
    end else if (LINK_SCL) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  // the clock stays low after a start until the first address bit
  assign start_pend = start_tgl ^ l.start_seen;
  assign stop_pend = stop_tgl ^ l.stop_seen;
  assign rx_byte = {l.shreg[6:0], SDA_IN};
  // floating straps are pulled low at the pad
  assign sel = HAS_SELECT_PINS ? l.sel_s2 : FIXED_SELECT;

  // ---- rising serial clock: receive, decode, plan next drive
  always_comb begin
    ln = l;
    ln.sel_s1 = {DEVICE_SELECT_BIT2, DEVICE_SELECT_BIT1, DEVICE_SELECT_BIT0};
    ln.sel_s2 = l.sel_s1;
    ln.busy_s1 = c.busy;
    ln.busy_s2 = l.busy_s1;
    ln.drv_low = 1'b0;
    if (start_pend) begin
      // core has taken any pending page at the earlier stop
      ln.start_seen = start_tgl;
      ln.stop_seen = stop_tgl;
      ln.wr_pend = 1'b0;
      ln.st = L_DEV;
      ln.cnt = FIRST_AFTER_START;
      ln.shreg = {7'h00, SDA_IN};
    end else if (stop_pend) begin
      ln.stop_seen = stop_tgl;
      ln.st = L_IDLE;
      ln.cnt = '0;
    end else if (l.st != L_IDLE) begin
      if (l.cnt == ACK_BIT) begin
        ln.cnt = '0;
        if (l.st == L_RDAT) begin
          ln.first_rd = 1'b0;
          if (l.first_rd || !SDA_IN) begin
            ln.tx = mem[l.cur];
            ln.cur = l.cur + 13'h0001;
            ln.drv_low = ~mem[l.cur][7];
          end else begin
            ln.st = L_IDLE;
          end
        end
      end else begin
        ln.cnt = l.cnt + 4'h1;
        ln.shreg = rx_byte;
        if (l.st == L_RDAT) begin
          if (l.cnt == LAST_BIT) begin
            ln.drv_low = 1'b0;
          end else begin
            ln.drv_low = ~l.tx[3'(BIT_TOP - l.cnt)];
          end
        end else if (l.cnt == LAST_BIT) begin
          case (l.st)
            L_DEV: begin
              if (rx_byte[7:4] == TYPE_CODE && rx_byte[3:1] == sel && !l.busy_s2) begin
                ln.drv_low = 1'b1;
                ln.st = rx_byte[0] ? L_RDAT : L_AHI;
                ln.first_rd = rx_byte[0];
              end else begin
                // refused: no acknowledge clock left pending while idle
                ln.st = L_IDLE;
                ln.cnt = '0;
              end
            end
            L_AHI: begin
              ln.ahi = rx_byte[4:0];
              ln.drv_low = 1'b1;
              ln.st = L_ALO;
            end
            L_ALO: begin
              ln.cur = {l.ahi, rx_byte};
              ln.page = {l.ahi, rx_byte[7:5]};
              ln.off = rx_byte[4:0];
              ln.mask = '0;
              ln.drv_low = 1'b1;
              ln.st = L_WDAT;
            end
            L_WDAT: begin
              if (d.wp_lat) begin
                ln.st = L_IDLE;
                ln.cnt = '0;
                ln.mask = '0;
                ln.wr_pend = 1'b0;
              end else begin
                ln.pbuf[l.off] = rx_byte;
                ln.mask[l.off] = 1'b1;
                ln.off = l.off + 5'h01;
                ln.cur = {l.page, l.off + 5'h01};
                ln.wr_pend = 1'b1;
                ln.drv_low = 1'b1;
              end
            end
            default: begin
              ln.st = L_IDLE;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge LINK_SCL or posedge RST) begin
    if (RST) begin
      l <= '0;
    end else begin
      l <= ln;
    end
  end

  // ---- falling serial clock: drive the line, strobe write protect
  always_comb begin
    dn = d;
    dn.sda_o = 1'b0;
    dn.oe_n = ~l.drv_low;
    dn.wp_s1 = WRITE_PROTECT;
    dn.wp_s2 = d.wp_s1;
    if (l.st == L_WDAT && l.cnt == 4'h0 && l.mask == '0) begin
      dn.wp_lat = d.wp_s2;
    end
  end

  always_ff @(negedge LINK_SCL or posedge RST) begin
    if (RST) begin
      d <= '0;
      d.oe_n <= 1'b1;
    end else begin
      d <= dn;
    end
  end

  assign SDA_OUT = d.sda_o;
  assign SDA_OE_N = d.oe_n;

  // ---- core clock: programming cycle after a stop
  assign stop_edge = c.stop_s2 ^ c.stop_s3;
  assign commit = c.st == C_PROG && c.cnt == PROG_LAST;

  always_comb begin
    cn = c;
    cn.stop_s1 = stop_tgl;
    cn.stop_s2 = c.stop_s1;
    cn.stop_s3 = c.stop_s2;
    cn.pend_s1 = l.wr_pend;
    cn.pend_s2 = c.pend_s1;
    case (c.st)
      C_IDLE: begin
        if (stop_edge && c.pend_s2) begin
          cn.st = C_PROG;
          cn.busy = 1'b1;
          cn.cnt = '0;
        end
      end
      C_PROG: begin
        if (commit) begin
          cn.st = C_IDLE;
          cn.busy = 1'b0;
        end else begin
          cn.cnt = c.cnt + 1'b1;
        end
      end
      default: begin
        cn.st = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      c <= '0;
    end else if (CE) begin
      c <= cn;
    end
  end

  // page buffer and mask stay still while busy refuses the bus
  always_ff @(posedge CORE_CLK) begin
    if (CE && commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (l.mask[i]) begin
          mem[{l.page, 5'(i)}] <= l.pbuf[i];
        end
      end
    end
  end

  // ---- checks
  property p_dev_ack;
    @(posedge LINK_SCL) disable iff (RST)
    (l.st == L_DEV && l.cnt == LAST_BIT && !start_pend && !stop_pend &&
     rx_byte[7:1] == {TYPE_CODE, sel} && !l.busy_s2)
    |=> (l.drv_low && (l.st == L_AHI || l.st == L_RDAT));
  endproperty
  a_dev_ack: assert property (p_dev_ack)
    else $error("matching address not acknowledged");

  property p_busy_nack;
    @(posedge LINK_SCL) disable iff (RST)
    (l.st == L_DEV && l.cnt == LAST_BIT && l.busy_s2 && !start_pend && !stop_pend)
    |=> (!l.drv_low && l.st == L_IDLE);
  endproperty
  a_busy_nack: assert property (p_busy_nack)
    else $error("address acknowledged while programming");

  property p_start;
    @(posedge LINK_SCL) disable iff (RST)
    start_pend |=> (l.st == L_DEV && l.cnt == FIRST_AFTER_START && !l.wr_pend);
  endproperty
  a_start: assert property (p_start)
    else $error("start did not open an address byte");

  property p_stop;
    @(posedge LINK_SCL) disable iff (RST)
    (stop_pend && !start_pend) |=> (l.st == L_IDLE && !l.drv_low);
  endproperty
  a_stop: assert property (p_stop)
    else $error("traffic after stop not ignored");

  property p_ack_release;
    @(posedge LINK_SCL) disable iff (RST)
    (l.cnt == ACK_BIT && l.st != L_RDAT && !start_pend && !stop_pend)
    |=> (!l.drv_low && l.cnt == 4'h0);
  endproperty
  a_ack_release: assert property (p_ack_release)
    else $error("line held after acknowledge clock");

  property p_wp_refuse;
    @(posedge LINK_SCL) disable iff (RST)
    (l.st == L_WDAT && l.cnt == LAST_BIT && d.wp_lat && !start_pend && !stop_pend)
    |=> (!l.drv_low && l.st == L_IDLE && l.mask == '0 && !l.wr_pend);
  endproperty
  a_wp_refuse: assert property (p_wp_refuse)
    else $error("protected write accepted");

  property p_page_wrap;
    @(posedge LINK_SCL) disable iff (RST)
    (l.st == L_WDAT && l.cnt == LAST_BIT && !d.wp_lat && !start_pend && !stop_pend)
    |=> (l.cur[12:5] == $past(l.page) && l.off == $past(l.off) + 5'h01 && l.wr_pend);
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("page offset did not wrap within page");

  property p_read_inc;
    @(posedge LINK_SCL) disable iff (RST)
    (l.st == L_RDAT && l.cnt == ACK_BIT && (l.first_rd || !SDA_IN) &&
     !start_pend && !stop_pend)
    |=> (l.cur == $past(l.cur) + 13'h0001 && l.drv_low == ~l.tx[7]);
  endproperty
  a_read_inc: assert property (p_read_inc)
    else $error("read address did not advance");

  property p_launch;
    @(posedge CORE_CLK) disable iff (RST)
    (CE && c.st == C_IDLE && stop_edge && c.pend_s2) |=> (c.busy && c.cnt == '0);
  endproperty
  a_launch: assert property (p_launch)
    else $error("stop after write did not start programming");

  property p_prog_hold;
    @(posedge CORE_CLK) disable iff (RST)
    $rose(c.busy) |-> c.busy[*4];
  endproperty
  a_prog_hold: assert property (p_prog_hold)
    else $error("programming cycle ended early");

  property p_rd_release;
    @(posedge LINK_SCL) disable iff (RST)
    (l.st == L_RDAT && l.cnt == LAST_BIT && !start_pend && !stop_pend) |=> !l.drv_low;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("line held during master acknowledge");

  property p_wp_strobe;
    @(negedge LINK_SCL) disable iff (RST)
    (l.st == L_WDAT && l.cnt == 4'h0 && l.mask == '0) |=> (d.wp_lat == $past(d.wp_s2));
  endproperty
  a_wp_strobe: assert property (p_wp_strobe)
    else $error("write protect not strobed before first data byte");

  property p_commit;
    @(posedge CORE_CLK) disable iff (RST)
    (CE && commit) |=> (!c.busy && c.st == C_IDLE);
  endproperty
  a_commit: assert property (p_commit)
    else $error("programming did not end after commit");

endmodule : eep_slave
`default_nettype wire

/* eep_master.sv */
// eep_master: behavioural two-wire bus master for the serial memory bench
// assumes an external pull-up, so a line nobody pulls low reads high
`timescale 1ns/100ps
`default_nettype none
module eep_master (
  // serial bus
  output var logic scl,
  output var logic pull_low,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end

  // one bit: data set in the low phase, sampled in the high phase
  task automatic bit_io(input logic b, output logic r);
    pull_low = ~b;
    #8 scl = 1'b1;
    #8 r = sda;
    #8 scl = 1'b0;
    #8;
  endtask : bit_io

  task automatic start();
    pull_low = 1'b0;
    #8 scl = 1'b1;
    #16 pull_low = 1'b1;
    #16 scl = 1'b0;
    #8;
  endtask : start

  // clock is left standing high after the stop
  task automatic stop();
    pull_low = 1'b1;
    #8 scl = 1'b1;
    #16 pull_low = 1'b0;
    #16;
  endtask : stop

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask : rd_byte
endmodule : eep_master
`default_nettype wire

/* i2c_serial_eeprom_slave_tb.sv */
// i2c_serial_eeprom_slave_tb: self-checking bench for the serial memory slave
// assumes eep_master as bus master; a shadow array predicts memory contents
`timescale 1ns/100ps
`default_nettype none
module i2c_serial_eeprom_slave_tb;
  import eep_pkg::*;
  localparam logic [2:0] SEL = 3'h5;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wp = 1'b0;
  logic scl;
  logic m_low;
  logic sda_out;
  logic sda_oe_n;
  logic fx_out;
  logic fx_oe_n;
  logic sda;
  logic [7:0] shadow [0:8191];
  logic [12:0] cur;
  int error_cnt = 0;
  int comparisons = 0;

  assign sda = ~(m_low | (~sda_oe_n & ~sda_out) | (~fx_oe_n & ~fx_out));
  always #5 core_clk = ~core_clk;

  eep_slave #(.PROG_CYCLES(100)) DUT (
    .CORE_CLK(core_clk), .CE(1'b1), .RST(rst), .LINK_SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .DEVICE_SELECT_BIT0(SEL[0]),
    .DEVICE_SELECT_BIT1(SEL[1]), .DEVICE_SELECT_BIT2(SEL[2]), .WRITE_PROTECT(wp));
  // build without select pins: its straps are wired but must not count
  eep_slave #(.PROG_CYCLES(100), .HAS_SELECT_PINS(1'b0), .FIXED_SELECT(SEL_FIXED_B))
    DUT_FIXED (
    .CORE_CLK(core_clk), .CE(1'b1), .RST(rst), .LINK_SCL(scl), .SDA_IN(sda),
    .SDA_OUT(fx_out), .SDA_OE_N(fx_oe_n), .DEVICE_SELECT_BIT0(SEL[0]),
    .DEVICE_SELECT_BIT1(SEL[1]), .DEVICE_SELECT_BIT2(SEL[2]), .WRITE_PROTECT(wp));
  eep_master M (.scl(scl), .pull_low(m_low), .sda(sda));

  task automatic test_done();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic chk_ack(input logic k, input logic e);
    check({7'h00, k}, {7'h00, e});
  endtask : chk_ack

  task automatic dev(input logic rd, output logic k);
    M.start();
    M.wr_byte({TYPE_CODE, SEL, rd}, k);
  endtask : dev

  task automatic set_addr(input logic [12:0] a);
    logic k;
    dev(1'b0, k);
    chk_ack(k, 1'b1);
    M.wr_byte({3'h0, a[12:8]}, k);
    chk_ack(k, 1'b1);
    M.wr_byte(a[7:0], k);
    chk_ack(k, 1'b1);
  endtask : set_addr

  // reads n bytes from the predicted current address, acking all but the last
  task automatic read_chk(input int n);
    logic k;
    logic [7:0] d;
    dev(1'b1, k);
    chk_ack(k, 1'b1);
    for (int i = 0; i < n; i++) begin
      M.rd_byte(i == n - 1, d);
      check(d, shadow[cur]);
      cur++;
    end
    M.stop();
  endtask : read_chk

  task automatic sel_read(input logic [12:0] a, input int n);
    set_addr(a);
    cur = a;
    read_chk(n);
  endtask : sel_read

  task automatic wait_prog();
    logic k;
    #64;
    dev(1'b0, k);
    chk_ack(k, 1'b0);
    for (int i = 0; i < 40 && !k; i++) begin
      M.stop();
      #64;
      dev(1'b0, k);
    end
    chk_ack(k, 1'b1);
    M.stop();
    #64;
  endtask : wait_prog

  task automatic write_page(input logic [12:0] a, input int n, input logic [7:0] base);
    logic k;
    logic [4:0] off;
    off = a[4:0];
    set_addr(a);
    for (int i = 0; i < n; i++) begin
      M.wr_byte(base + 8'(i), k);
      chk_ack(k, 1'b1);
      shadow[{a[12:5], off}] = base + 8'(i);
      off++;
    end
    M.stop();
    cur = {a[12:5], off};
    wait_prog();
  endtask : write_page

  task automatic s_no_start();
    logic r;
    for (int i = 0; i < 4; i++) begin
      M.bit_io(1'b1, r);
      check({7'h00, sda_oe_n}, 8'h01);
      check({7'h00, sda_out}, 8'h00);
    end
  endtask : s_no_start

  task automatic s_wrong_addr();
    logic k;
    M.start();
    M.wr_byte({TYPE_CODE, ~SEL, 1'b0}, k);
    chk_ack(k, 1'b0);
    M.start();
    M.wr_byte({4'h5, SEL, 1'b1}, k);
    chk_ack(k, 1'b0);
    M.stop();
    #64;
  endtask : s_wrong_addr

  // a matching address clocked after a stop, with no new start, gets no ack
  task automatic s_stop_ends();
    logic k;
    set_addr(13'h0200);
    M.stop();
    M.wr_byte({TYPE_CODE, SEL, 1'b0}, k);
    chk_ack(k, 1'b0);
    M.stop();
    #64;
  endtask : s_stop_ends

  // the pinless build answers its fixed select bits, whatever its straps say
  task automatic s_fixed_sel();
    logic k;
    logic [7:0] d;
    M.start();
    M.wr_byte({TYPE_CODE, SEL_FIXED_B, 1'b1}, k);
    chk_ack(k, 1'b1);
    M.rd_byte(1'b1, d);
    check(d, ERASED);
    M.stop();
    #64;
  endtask : s_fixed_sel

  task automatic s_protect();
    logic k;
    @(posedge core_clk) #1 wp = 1'b1;
    set_addr(13'h0100);
    M.wr_byte(8'h77, k);
    chk_ack(k, 1'b0);
    M.stop();
    @(posedge core_clk) #1 wp = 1'b0;
    #64;
    sel_read(13'h0100, 1);
  endtask : s_protect

  task automatic s_page_wrap();
    write_page(13'h005E, 34, 8'h10);
    sel_read(13'h0040, 32);
    read_chk(1);
  endtask : s_page_wrap

  initial begin
    for (int i = 0; i < 8192; i++) begin
      shadow[i] = ERASED;
    end
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    s_no_start();
    sel_read(13'h0123, 2);
    write_page(13'h0040, 1, 8'h5A);
    sel_read(13'h003F, 3);
    s_page_wrap();
    s_wrong_addr();
    s_stop_ends();
    s_fixed_sel();
    s_protect();
    write_page(13'h1FFF, 1, 8'hC3);
    sel_read(13'h1FFE, 3);
    test_done();
  end

  initial begin
    #500_000;
    error_cnt++;
    test_done();
  end
endmodule : i2c_serial_eeprom_slave_tb
`default_nettype wire
